// >>> rtl/burst2_port_pkg.sv
// Constants shared by the burst-of-two memory port design.
// Assumes a 100 MHz system clock that oversamples the pin clocks.
package burst2_port_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W = 36;
	localparam int HALF_W = 18;
	localparam int ADDR_W = 19;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DEPTH = 64;
	localparam int IDX_W = 6;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int LOCK_TIME_NS = 20480;
	localparam int LOCK_CYCLES = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int LOCK_W = 18;
	localparam logic [2:0] PIPE_DLL = 3'h4;
	localparam logic [2:0] PIPE_BYP = 3'h1;
	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic {CFG_X18, CFG_X36} width_cfg_t;
	typedef enum {LOOP_OFF, LOOP_LOCKING, LOOP_LOCKED} loop_state_t;
endpackage

// >>> rtl/pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes the destination clock is clk_i.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;
	// Stages run through reset, so release shows no false pin edge
	always_ff @(posedge clk_i) begin
		meta_reg <= async_i;
		sync_o <= meta_reg;
	end
	wire unused_ok = rstn_i;
endmodule
`default_nettype wire

// >>> rtl/burst2_sram_port.sv
// Device-side logic of a burst-of-two double-data-rate memory port.
// Assumes the pin clocks are slow enough to be oversampled by clk_i.
// Notes on behaviour
// - Address and control taken on true rise
// - Write data taken on both rises
// - Echo clocks toggle always, even idle
// - Echo edges aligned to data changes
// - Bypass low: skip loop, drop lock
// - Bypass high: relock, controller waits
// - Bypass gives one clock read latency
// - Valid flag marks data, echo aligned
// - Address registered on true rise
// - Address ignored without read or write
// - Narrow mode uses lower eighteen lines
// - Read outputs change only for reads
// - Read data launched with echo clocks
// - Write strobe low starts write cycle
// - Read strobe low starts two-beat read
// - Loop on: first beat at 2.5 cycles
// - Lane masks sampled with their beat
`timescale 1ns/10ps
`default_nettype none
module burst2_sram_port
	import burst2_port_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic clk_true_i,
	input wire logic clk_comp_i,
	input wire logic loop_enable_n_i,
	input wire logic width_sel_i,
	input wire logic read_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic [ADDR_W-1:0] addr_in_i,
	input wire logic [DATA_W-1:0] write_data_in_i,
	input wire logic [LANES-1:0] lane_write_mask_n_i,
	output logic echo_timing_out_o,
	output logic echo_timing_out_bar_o,
	output logic output_valid_flag_o,
	output logic read_data_oe_o,
	output logic [DATA_W-1:0] read_data_out_o,
	output logic loop_locked_o
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int SW = 6 + ADDR_W + DATA_W + LANES;
	logic [SW-1:0] pins_s;
	logic kt_s, kc_s, bypass_n_s, rd_n_s, wr_n_s, width_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] din_s;
	logic [LANES-1:0] mask_n_s;
	pin_sync #(.W(SW)) u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.async_i({clk_true_i, clk_comp_i, loop_enable_n_i, read_strobe_n_i,
			write_strobe_n_i, width_sel_i, addr_in_i, write_data_in_i,
			lane_write_mask_n_i}),
		.sync_o(pins_s)
	);
	assign {kt_s, kc_s, bypass_n_s, rd_n_s, wr_n_s, width_s, addr_s, din_s,
		mask_n_s} = pins_s;
	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	logic kt_d_reg, kc_d_reg;
	wire kt_rise = kt_s & ~kt_d_reg;
	wire kc_rise = kc_s & ~kc_d_reg;
	// History follows the pins through reset: no false edge on release
	always_ff @(posedge clk_i) begin
		kt_d_reg <= kt_s;
		kc_d_reg <= kc_s;
	end
	// ----------------------------------------
	// Width strap
	// ----------------------------------------
	width_cfg_t cfg_reg;
	logic strap_done_reg;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cfg_reg <= CFG_X36;
			strap_done_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			cfg_reg <= width_s ? CFG_X36 : CFG_X18;
			strap_done_reg <= 1'b1;
		end
	end
	wire [DATA_W-1:0] width_mask = (cfg_reg == CFG_X18) ?
		{{(DATA_W-HALF_W){1'b0}}, {HALF_W{1'b1}}} : {DATA_W{1'b1}};
	// ----------------------------------------
	// Delay loop model
	// ----------------------------------------
	loop_state_t loop_reg, loop_next;
	logic [LOCK_W-1:0] lock_cnt_reg;
	wire lock_done = (lock_cnt_reg == LOCK_W'(LOCK_CYCLES - 1));
	always_comb begin
		loop_next = loop_reg;
		case (loop_reg)
			LOOP_OFF: if (bypass_n_s) loop_next = LOOP_LOCKING;
			LOOP_LOCKING: if (!bypass_n_s) loop_next = LOOP_OFF;
				else if (lock_done) loop_next = LOOP_LOCKED;
			LOOP_LOCKED: if (!bypass_n_s) loop_next = LOOP_OFF;
			default: loop_next = LOOP_OFF;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			loop_reg <= LOOP_OFF;
			lock_cnt_reg <= '0;
			loop_locked_o <= 1'b0;
		end else begin
			loop_reg <= loop_next;
			if (loop_next != LOOP_LOCKING) lock_cnt_reg <= '0;
			else lock_cnt_reg <= lock_cnt_reg + 1'b1;
			loop_locked_o <= (loop_next == LOOP_LOCKED);
		end
	end
	wire loop_on = (loop_reg == LOOP_LOCKED);
	// ----------------------------------------
	// Write capture
	// ----------------------------------------
	logic wr_pend_reg;
	logic [ADDR_W-1:0] wr_addr_reg;
	logic [DATA_W-1:0] beat0_reg;
	logic [LANES-1:0] mask0_n_reg;
	wire wr_req = kt_rise & ~wr_n_s;
	wire rd_req = kt_rise & ~rd_n_s;
	wire addr_take = rd_req | wr_req;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			beat0_reg <= '0;
			mask0_n_reg <= '1;
		end else if (wr_req) begin
			wr_pend_reg <= 1'b1;
			wr_addr_reg <= addr_s;
			beat0_reg <= din_s & width_mask;
			mask0_n_reg <= mask_n_s;
		end else if (kc_rise) begin
			wr_pend_reg <= 1'b0;
		end
	end
	wire wr_commit = wr_pend_reg & kc_rise;
	wire [IDX_W-1:0] wr_idx0 = {wr_addr_reg[IDX_W-2:0], 1'b0};
	wire [IDX_W-1:0] wr_idx1 = {wr_addr_reg[IDX_W-2:0], 1'b1};
	wire [DATA_W-1:0] beat1 = din_s & width_mask;
	wire [IDX_W-1:0] rd_sel_idx;
	wire [DATA_W-1:0] rd_word;
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			// Each lane owns its storage, so one process drives it
			logic [LANE_W-1:0] lane_mem [DEPTH];
			always_ff @(posedge clk_i) begin
				if (wr_commit && !mask0_n_reg[g])
					lane_mem[wr_idx0] <= beat0_reg[g*LANE_W +: LANE_W];
				if (wr_commit && !mask_n_s[g])
					lane_mem[wr_idx1] <= beat1[g*LANE_W +: LANE_W];
			end
			assign rd_word[g*LANE_W +: LANE_W] = lane_mem[rd_sel_idx];
		end
	endgenerate
	// ----------------------------------------
	// Read pipeline
	// ----------------------------------------
	logic [2:0] rd_cnt_reg;
	logic rd_pend_reg, beat_sel_reg, second_due_reg;
	logic [IDX_W-1:0] rd_idx_reg;
	wire [2:0] pipe_len = loop_on ? PIPE_DLL : PIPE_BYP;
	wire half_edge = kt_rise | kc_rise;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rd_pend_reg <= 1'b0;
			rd_cnt_reg <= '0;
			rd_idx_reg <= '0;
		end else if (rd_req) begin
			rd_pend_reg <= 1'b1;
			rd_cnt_reg <= pipe_len;
			rd_idx_reg <= {addr_s[IDX_W-2:0], 1'b0};
		end else if (rd_pend_reg && half_edge) begin
			if (rd_cnt_reg == 3'h0) rd_pend_reg <= 1'b0;
			else rd_cnt_reg <= rd_cnt_reg - 1'b1;
		end
	end
	wire launch_first = rd_pend_reg & half_edge & (rd_cnt_reg == 3'h0);
	wire launch_second = second_due_reg & half_edge;
	assign rd_sel_idx = launch_first ? rd_idx_reg : (rd_idx_reg | IDX_W'(beat_sel_reg));
	// ----------------------------------------
	// Output stage
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			second_due_reg <= 1'b0;
			beat_sel_reg <= 1'b0;
			read_data_out_o <= '0;
			output_valid_flag_o <= 1'b0;
			read_data_oe_o <= 1'b0;
			echo_timing_out_o <= 1'b0;
			echo_timing_out_bar_o <= 1'b1;
		end else begin
			if (kt_rise) begin
				echo_timing_out_o <= 1'b1;
				echo_timing_out_bar_o <= 1'b0;
			end else if (kc_rise) begin
				echo_timing_out_o <= 1'b0;
				echo_timing_out_bar_o <= 1'b1;
			end
			if (launch_first) begin
				read_data_out_o <= rd_word & width_mask;
				second_due_reg <= 1'b1;
				beat_sel_reg <= 1'b1;
				output_valid_flag_o <= 1'b1;
				read_data_oe_o <= 1'b1;
			end else if (launch_second) begin
				read_data_out_o <= rd_word & width_mask;
				second_due_reg <= 1'b0;
				beat_sel_reg <= 1'b0;
			end else if (half_edge && !second_due_reg) begin
				output_valid_flag_o <= 1'b0;
				read_data_oe_o <= 1'b0;
			end
		end
	end
	wire unused_ok = &{1'b0, addr_take};
endmodule
`default_nettype wire

// >>> sim/burst2_port_sva.sv
// Pin checker of the burst-of-two memory port.
// Assumes a bind to burst2_sram_port.
`timescale 1ns/10ps
`default_nettype none
module burst2_port_sva (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic clk_true_i,
	input wire logic loop_enable_n_i,
	input wire logic echo_timing_out_o,
	input wire logic echo_timing_out_bar_o,
	input wire logic output_valid_flag_o,
	input wire logic read_data_oe_o,
	input wire logic [35:0] read_data_out_o,
	input wire logic loop_locked_o
);
	// --------
	// Checks
	// --------
	logic [11:0] up_reg;
	always_ff @(posedge clk_i) begin
		up_reg <= (!rstn_i || !loop_enable_n_i) ? 12'h000 : up_reg + {11'h000, ~&up_reg};
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	a_echo_pair: assert property (
		echo_timing_out_bar_o == !echo_timing_out_o
	) else $error("echo pair not inverse");
	a_echo_runs: assert property (
		$rose(echo_timing_out_o) |-> ##[6:10] $fell(echo_timing_out_o)
	) else $error("echo stopped");
	a_echo_true: assert property (
		$rose(clk_true_i) |-> ##[2:5] $rose(echo_timing_out_o)
	) else $error("echo not after true rise");
	a_valid_aligned: assert property (
		$changed(output_valid_flag_o) |-> $changed(echo_timing_out_o)
	) else $error("valid off echo edge");
	a_data_on_read: assert property (
		$changed(read_data_out_o) |-> output_valid_flag_o && read_data_oe_o && $changed(echo_timing_out_o)
	) else $error("data moved outside a read beat");
	a_two_beats: assert property (
		$rose(output_valid_flag_o) |-> output_valid_flag_o[*8] ##1 output_valid_flag_o[*8] ##1 !output_valid_flag_o
	) else $error("valid not two beats");
	a_bypass_unlock: assert property (
		!loop_enable_n_i [*5] |-> !loop_locked_o
	) else $error("lock kept in bypass");
	a_lock_late: assert property (
		$rose(loop_locked_o) |-> up_reg >= 12'h800
	) else $error("lock too early");
endmodule
bind burst2_sram_port burst2_port_sva i_burst2_port_sva (
	.clk_i(clk_i),
	.rstn_i(rstn_i),
	.clk_true_i(clk_true_i),
	.loop_enable_n_i(loop_enable_n_i),
	.echo_timing_out_o(echo_timing_out_o),
	.echo_timing_out_bar_o(echo_timing_out_bar_o),
	.output_valid_flag_o(output_valid_flag_o),
	.read_data_oe_o(read_data_oe_o),
	.read_data_out_o(read_data_out_o),
	.loop_locked_o(loop_locked_o)
);
`default_nettype wire

// >>> sim/ctrl_model.sv
// Controller model: pin clock pair and request tasks.
// Assumes clk_i at 100 MHz; one pin period is 16 cycles.
`timescale 1ns/10ps
`default_nettype none
module ctrl_model (
	input wire logic clk_i,
	output wire logic clk_true_o,
	output wire logic clk_comp_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [18:0] addr_o,
	output logic [35:0] data_o,
	output logic [3:0] mask_n_o
);
	// --------
	// Pin drive
	// --------
	logic [3:0] ph_reg = 4'h0;
	assign clk_true_o = !ph_reg[3];
	assign clk_comp_o = ph_reg[3];
	always @(posedge clk_i) ph_reg <= #1 ph_reg + 4'h1;
	initial begin
		{rd_n_o, wr_n_o, mask_n_o} = 6'h3F;
		addr_o = 19'h00000;
		data_o = 36'h000000000;
	end
	task automatic step(input logic [3:0] p);
		@(posedge clk_i);
		while (ph_reg != p) @(posedge clk_i);
		#1;
	endtask
	task automatic write2(input logic [18:0] a, input logic [35:0] d0, d1,
		input logic [3:0] m0, m1);
		step(4'hD);
		{wr_n_o, addr_o, data_o, mask_n_o} = {1'b0, a, d0, m0};
		step(4'h5);
		{wr_n_o, addr_o, data_o, mask_n_o} = {1'b1, ~a, d1, m1};
		step(4'hD);
		data_o = ~d1;
	endtask
	task automatic read2(input logic [18:0] a);
		step(4'hD);
		{rd_n_o, addr_o} = {1'b0, a};
		step(4'h5);
		{rd_n_o, addr_o} = {1'b1, ~a};
	endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Testbench of the burst-of-two port against a controller model.
// Assumes the model owns the pin clocks and issues every request.
`timescale 1ns/10ps
`default_nettype none
module testbench
	import burst2_port_pkg::*;
;
	localparam logic [35:0] d_a = 36'h123456789;
	localparam logic [35:0] d_b = 36'hFEDCBA987;
	localparam logic [35:0] d_c = 36'h0F0F0F0F0;
	localparam logic [35:0] d_mix = (d_a & ~36'h00003FE00) | (d_c & 36'h00003FE00);
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic loop_enable_n_i = 1'b0;
	logic width_sel_i = 1'b1;
	wire logic clk_true_i, clk_comp_i, read_strobe_n_i, write_strobe_n_i;
	wire logic [ADDR_W-1:0] addr_in_i;
	wire logic [DATA_W-1:0] write_data_in_i;
	wire logic [LANES-1:0] lane_write_mask_n_i;
	logic echo_timing_out_o, echo_timing_out_bar_o, output_valid_flag_o, read_data_oe_o;
	logic loop_locked_o;
	logic [DATA_W-1:0] read_data_out_o;
	int errors = 0;
	int n_compared = 0;
	burst2_sram_port i_burst2_sram_port (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.clk_true_i(clk_true_i),
		.clk_comp_i(clk_comp_i),
		.loop_enable_n_i(loop_enable_n_i),
		.width_sel_i(width_sel_i),
		.read_strobe_n_i(read_strobe_n_i),
		.write_strobe_n_i(write_strobe_n_i),
		.addr_in_i(addr_in_i),
		.write_data_in_i(write_data_in_i),
		.lane_write_mask_n_i(lane_write_mask_n_i),
		.echo_timing_out_o(echo_timing_out_o),
		.echo_timing_out_bar_o(echo_timing_out_bar_o),
		.output_valid_flag_o(output_valid_flag_o),
		.read_data_oe_o(read_data_oe_o),
		.read_data_out_o(read_data_out_o),
		.loop_locked_o(loop_locked_o)
	);
	ctrl_model i_ctrl_model (.clk_i(clk_i), .clk_true_o(clk_true_i), .clk_comp_o(clk_comp_i),
		.rd_n_o(read_strobe_n_i), .wr_n_o(write_strobe_n_i), .addr_o(addr_in_i),
		.data_o(write_data_in_i), .mask_n_o(lane_write_mask_n_i));
	initial forever #5 clk_i = ~clk_i;
	// --------
	// Tasks
	// --------
	task automatic check(input string n, input logic [35:0] e, g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic reset_dut(input logic w);
		@(posedge clk_i);
		#1 rstn_i = 1'b0;
		width_sel_i = w;
		repeat (4) @(posedge clk_i);
		#1 rstn_i = 1'b1;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic read_chk(input logic [18:0] a, input logic [35:0] e0, e1, input int lo, hi);
		int n;
		i_ctrl_model.read2(a);
		n = 0;
		while (output_valid_flag_o !== 1'b1 && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		check("latency", 36'h1, 36'(n >= lo && n <= hi));
		check("beat0", e0, read_data_out_o);
		check("oe", 36'h1, 36'(read_data_oe_o));
		repeat (8) @(negedge clk_i);
		check("beat1", e1, read_data_out_o);
		repeat (8) @(negedge clk_i);
		check("valid end", 36'h0, 36'({output_valid_flag_o, read_data_oe_o}));
	endtask
	task automatic test_bypass();
		reset_dut(1'b1);
		check("locked", 36'h0, 36'(loop_locked_o));
		i_ctrl_model.write2(19'h00005, d_a, d_b, 4'h0, 4'h0);
		read_chk(19'h00005, d_a, d_b, 13, 15);
		i_ctrl_model.write2(19'h00005, d_c, d_c, 4'hD, 4'h0);
		read_chk(19'h00005, d_mix, d_c, 13, 15);
		$display("test_bypass done");
	endtask
	task automatic test_lock();
		int n;
		@(posedge clk_i);
		#1 loop_enable_n_i = 1'b1;
		n = 0;
		while (loop_locked_o !== 1'b1 && n < 2300) begin
			@(negedge clk_i);
			n++;
		end
		check("lock time", 36'h1, 36'(n >= 2048 && n < 2300));
		read_chk(19'h00005, d_mix, d_c, 37, 39);
		@(posedge clk_i);
		#1 loop_enable_n_i = 1'b0;
		repeat (8) @(negedge clk_i);
		check("unlock", 36'h0, 36'(loop_locked_o));
		$display("test_lock done");
	endtask
	task automatic test_narrow();
		reset_dut(1'b0);
		i_ctrl_model.write2(19'h00007, d_a, d_b, 4'h0, 4'h0);
		read_chk(19'h00007, {18'h00000, d_a[17:0]}, {18'h00000, d_b[17:0]}, 13, 15);
		$display("test_narrow done");
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		test_bypass();
		test_lock();
		test_narrow();
		print_verdict();
	end
	initial begin
		#300000;
		errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
